// ---- pfd_defs.svh ----
// Constant macros for the fault input and dither block.
`ifndef PFD_DEFS_SVH
`define PFD_DEFS_SVH
`define PFD_CNT_W        12
`define PFD_DIT_W        4
`define PFD_MODE_W       4
`define PFD_MODE_NONE    4'h0
`define PFD_MODE_WAIT    4'h1
`define PFD_MODE_RUN_WT  4'h2
`define PFD_MODE_RUN     4'h3
`define PFD_MODE_ALLOFF  4'h4
`define PFD_MODE_DTONLY  4'h5
`define PFD_MODE_ALLWAIT 4'h6
`define PFD_MODE_SWSTOP  4'h7
`define PFD_MODE_EDGEJMP 4'h8
`define PFD_MODE_EDGEBLK 4'h9
`define PFD_MODE_LEVBLK  4'ha
`define PFD_SYNC_STAGES  2
`endif

// ---- pfd_pkg.sv ----
// Types shared by the fault input and dither block.
`include "pfd_defs.svh"
package pfd_pkg;
   typedef enum logic [2:0] {
      ST_DTA  = 3'b000,
      ST_OTA  = 3'b001,
      ST_DTB  = 3'b010,
      ST_OTB  = 3'b011,
      ST_HOLD = 3'b100,
      ST_STOP = 3'b101
   } pfd_state_t;
   typedef enum logic [1:0] {
      WGM_ONE  = 2'b00,
      WGM_TWO  = 2'b01,
      WGM_FOUR = 2'b10,
      WGM_DUAL = 2'b11
   } pfd_wgm_t;
   typedef enum logic [1:0] {
      DSEL_OTB  = 2'b00,
      DSEL_OTAB = 2'b01,
      DSEL_DTB  = 2'b10,
      DSEL_DTAB = 2'b11
   } pfd_dsel_t;
   typedef struct packed {
      logic [`PFD_CNT_W-1:0] dta;
      logic [`PFD_CNT_W-1:0] ota;
      logic [`PFD_CNT_W-1:0] dtb;
      logic [`PFD_CNT_W-1:0] otb;
   } pfd_times_t;
endpackage

// ---- pfd_sync.sv ----
// Two-stage synchroniser for the asynchronous fault inputs.
`timescale 1ns/100ps
module pfd_sync #(
   parameter int W = 2
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   if (W < 1) begin : g_chk
      $error("pfd_sync: width must be at least one");
   end
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge ref_clk_i) begin
         if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
         end else begin
            meta_q <= async_i[i];
            sync_q <= meta_q;
         end
      end
      assign sync_o[i] = sync_q;
   end
endmodule // pfd_sync

// ---- pfd_dither.sv ----
// Fractional period accumulator that flags one extra counter clock.
`timescale 1ns/100ps
module pfd_dither #(
   parameter int DIT_W = 4
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             cycle_end_i,
   input  wire logic [DIT_W-1:0] frac_i,
   output logic                  ovf_o
);
   logic [DIT_W-1:0] acc_q;
   logic [DIT_W-1:0] acc_d;
   logic             ovf_q;
   logic             ovf_d;
   logic [DIT_W:0]   sum;

   if (DIT_W < 1 || DIT_W > 12) begin : g_chk
      $error("pfd_dither: fraction width out of range");
   end

   // The overflow is held for a whole timer cycle so the sequencer can
   // place the extra clock anywhere within it.
   always_comb begin
      sum   = {1'b0, acc_q} + {1'b0, frac_i};
      acc_d = acc_q;
      ovf_d = ovf_q;
      if (cycle_end_i) begin
         acc_d = sum[DIT_W-1:0];
         ovf_d = sum[DIT_W];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         acc_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         ovf_q <= ovf_d;
      end
   end

   assign ovf_o = ovf_q;
endmodule // pfd_dither

// ---- pfd_fault_dither.sv ----
// Fault input reaction and dither placement for the control timer.
`timescale 1ns/100ps
`include "pfd_defs.svh"
module pfd_fault_dither #(
   parameter int DIT_W = `PFD_DIT_W
) (
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     enable_i,
   input  wire logic                     fault_a_i,
   input  wire logic                     fault_b_i,
   input  wire logic                     restart_i,
   input  wire logic [`PFD_MODE_W-1:0]   fault_input_mode_i,
   input  wire pfd_pkg::pfd_wgm_t        waveform_generation_mode_i,
   input  wire pfd_pkg::pfd_dsel_t       dither_place_select_i,
   input  wire logic [DIT_W-1:0]         dither_frac_i,
   input  wire pfd_pkg::pfd_times_t      times_i,
   output logic                          waveform_out_a_o,
   output logic                          waveform_out_b_o,
   output pfd_pkg::pfd_state_t           state_o,
   output logic                          cycle_end_o
);
   import pfd_pkg::*;

   localparam pfd_state_t DT_OWN [2] = '{ST_DTA, ST_DTB};
   localparam pfd_state_t OT_OWN [2] = '{ST_OTA, ST_OTB};
   localparam pfd_state_t DT_OTH [2] = '{ST_DTB, ST_DTA};
   localparam pfd_state_t OT_OTH [2] = '{ST_OTB, ST_OTA};
   localparam logic [1:0] CH_BIT [2] = '{2'b01, 2'b10};

   if (DIT_W < 1 || DIT_W > `PFD_CNT_W) begin : g_chk
      $error("pfd_fault_dither: dither width out of range");
   end

   logic [1:0]            flt;
   logic [1:0]            flt_q;
   logic [1:0]            rise;
   logic                  any;
   logic [1:0]            own;
   logic [1:0]            kill;
   pfd_state_t            st_q;
   pfd_state_t            st_d;
   pfd_state_t            res_q;
   pfd_state_t            res_d;
   logic [`PFD_CNT_W-1:0] cnt_q;
   logic [`PFD_CNT_W-1:0] cnt_d;
   logic [`PFD_CNT_W-1:0] base;
   logic [`PFD_CNT_W:0]   end_cnt;
   logic [1:0]            blk_q;
   logic [1:0]            blk_d;
   logic [1:0]            pend_q;
   logic [1:0]            pend_d;
   logic [1:0]            hmask_q;
   logic [1:0]            hmask_d;
   logic                  comp_q;
   logic                  comp_d;
   logic                  wo_a_q;
   logic                  wo_a_d;
   logic                  wo_b_q;
   logic                  wo_b_d;
   logic                  cyc_q;
   logic                  cyc_d;
   logic                  ovf;
   logic                  sel_on;
   logic                  sel_a;
   logic                  add_a;
   logic                  add_b;
   logic                  stretch;
   logic                  adds;
   logic                  shr;
   logic                  done;
   logic [`PFD_MODE_W-1:0] mode;

   pfd_sync #(
      .W (2)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   ({fault_b_i, fault_a_i}),
      .sync_o    (flt)
   );

   // The carry is taken as on-time B ends, so it is already valid in the
   // first clock of dead-time A even when that state lasts one clock.
   pfd_dither #(
      .DIT_W (DIT_W)
   ) u_dither (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .cycle_end_i (cyc_d),
      .frac_i      (dither_frac_i),
      .ovf_o       (ovf)
   );

   assign mode = fault_input_mode_i;
   assign rise = flt & ~flt_q;
   assign any  = |flt;
   assign own  = {st_q == ST_DTB || st_q == ST_OTB,
                  st_q == ST_DTA || st_q == ST_OTA};

   // Where the extra clock lands and whether it lengthens the cycle.
   always_comb begin
      sel_on = dither_place_select_i inside {DSEL_OTB, DSEL_OTAB};
      sel_a  = dither_place_select_i inside {DSEL_OTAB, DSEL_DTAB};
      unique case (waveform_generation_mode_i)
         WGM_ONE: begin
            add_b = sel_on;
            add_a = 1'b0;
         end
         WGM_TWO: begin
            add_b = sel_on;
            add_a = sel_on;
         end
         WGM_FOUR: begin
            add_b = 1'b1;
            add_a = 1'b1;
         end
         WGM_DUAL: begin
            add_b = 1'b0;
            add_a = 1'b0;
         end
      endcase
      stretch = 1'b0;
      adds    = 1'b0;
      base    = '0;
      unique case (st_q)
         ST_DTA: begin
            stretch = ~sel_on & sel_a;
            adds    = add_a;
            base    = times_i.dta;
         end
         ST_OTA: begin
            stretch = sel_on & sel_a;
            adds    = add_a;
            base    = times_i.ota;
         end
         ST_DTB: begin
            stretch = ~sel_on;
            adds    = add_b;
            base    = times_i.dtb;
         end
         ST_OTB: begin
            stretch = sel_on;
            adds    = add_b;
            base    = times_i.otb;
         end
         default: ;
      endcase
      stretch = stretch & ovf &
                (waveform_generation_mode_i != WGM_DUAL);
      shr     = comp_q & (base != '0);
      end_cnt = {1'b0, base} + {{`PFD_CNT_W{1'b0}}, stretch}
              - {{`PFD_CNT_W{1'b0}}, shr};
      done    = {1'b0, cnt_q} >= end_cnt;
   end

   always_comb begin
      st_d    = st_q;
      res_d   = res_q;
      cnt_d   = cnt_q + 12'h001;
      blk_d   = blk_q;
      pend_d  = pend_q;
      hmask_d = hmask_q;
      comp_d  = comp_q;
      cyc_d   = 1'b0;
      kill    = 2'b00;
      if (done && st_q inside {ST_DTA, ST_OTA, ST_DTB, ST_OTB}) begin
         cnt_d  = '0;
         comp_d = stretch & ~adds;
         cyc_d  = st_q == ST_OTB;
         unique case (st_q)
            ST_DTA:  st_d = ST_OTA;
            ST_OTA:  st_d = ST_DTB;
            ST_DTB:  st_d = ST_OTB;
            default: st_d = ST_DTA;
         endcase
      end
      if (st_q == ST_HOLD) begin
         cnt_d = cnt_q;
         if ((flt & hmask_q) == 2'b00) begin
            st_d  = res_q;
            cnt_d = '0;
         end
      end
      if (st_q == ST_STOP) begin
         cnt_d = cnt_q;
         if (restart_i) begin
            st_d  = ST_DTA;
            cnt_d = '0;
         end
      end
      // Each input only steers its own output in these modes.
      for (int c = 0; c < 2; c++) begin
         case (mode)
            `PFD_MODE_WAIT: begin
               kill[c] = flt[c];
               if (flt[c] && own[c]) begin
                  st_d    = ST_HOLD;
                  res_d   = DT_OTH[c];
                  hmask_d = CH_BIT[c];
                  cnt_d   = '0;
                  comp_d  = 1'b0;
               end
            end
            `PFD_MODE_RUN_WT: begin
               kill[c] = flt[c];
               if (flt[c] && own[c] && !pend_q[c]) begin
                  st_d      = DT_OTH[c];
                  cnt_d     = '0;
                  comp_d    = 1'b0;
                  pend_d[c] = 1'b1;
               end
               if (pend_q[c] && st_q == OT_OTH[c] && done) begin
                  pend_d[c] = 1'b0;
                  if (flt[c]) begin
                     st_d    = ST_HOLD;
                     res_d   = DT_OWN[c];
                     hmask_d = CH_BIT[c];
                  end
               end
            end
            `PFD_MODE_RUN: begin
               kill[c] = flt[c];
               if (flt[c] && own[c]) begin
                  st_d   = DT_OTH[c];
                  cnt_d  = '0;
                  comp_d = 1'b0;
               end
               if (flt[c] && st_q == OT_OTH[c] && done) begin
                  st_d = DT_OTH[c];
               end
            end
            `PFD_MODE_EDGEJMP: begin
               if (rise[c] && st_q == OT_OWN[c]) begin
                  st_d   = DT_OTH[c];
                  cnt_d  = '0;
                  comp_d = 1'b0;
               end
            end
            `PFD_MODE_EDGEBLK: begin
               if (rise[c] && st_q == OT_OWN[c]) begin
                  blk_d[c] = 1'b1;
               end
            end
            `PFD_MODE_LEVBLK: begin
               kill[c] = flt[c];
               if (flt[c] && st_q == OT_OWN[c]) begin
                  blk_d[c] = 1'b1;
               end
            end
            default: ;
         endcase
      end
      case (mode)
         `PFD_MODE_ALLOFF: kill = {2{any}};
         `PFD_MODE_DTONLY: begin
            kill = {2{any}};
            if (any && st_q inside {ST_OTA, ST_OTB}) begin
               st_d   = (st_q == ST_OTA) ? ST_DTB : ST_DTA;
               cnt_d  = '0;
               comp_d = 1'b0;
            end else if (any && done && st_q inside {ST_DTA, ST_DTB}) begin
               st_d   = (st_q == ST_DTA) ? ST_DTB : ST_DTA;
               comp_d = 1'b0;
            end
         end
         `PFD_MODE_ALLWAIT: begin
            kill = {2{any}};
            if (any && (st_q inside {ST_OTA, ST_OTB} ||
                        (done && st_q inside {ST_DTA, ST_DTB}))) begin
               st_d    = ST_HOLD;
               res_d   = (st_q inside {ST_DTA, ST_OTA}) ? ST_DTB : ST_DTA;
               hmask_d = 2'b11;
               cnt_d   = '0;
               comp_d  = 1'b0;
            end
         end
         `PFD_MODE_SWSTOP: begin
            kill = {2{any}};
            if (any && st_q != ST_STOP) begin
               st_d   = ST_STOP;
               cnt_d  = cnt_q;
               comp_d = 1'b0;
            end
         end
         default: ;
      endcase
      for (int c = 0; c < 2; c++) begin
         if (st_d != OT_OWN[c]) begin
            blk_d[c] = 1'b0;
         end
      end
      if (!enable_i) begin
         st_d    = ST_DTA;
         res_d   = ST_DTA;
         cnt_d   = '0;
         blk_d   = 2'b00;
         pend_d  = 2'b00;
         hmask_d = 2'b00;
         comp_d  = 1'b0;
         cyc_d   = 1'b0;
      end
      wo_a_d = st_d == ST_OTA && !blk_d[0] && !kill[0];
      wo_b_d = st_d == ST_OTB && !blk_d[1] && !kill[1];
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         flt_q   <= 2'b00;
         st_q    <= ST_DTA;
         res_q   <= ST_DTA;
         cnt_q   <= '0;
         blk_q   <= 2'b00;
         pend_q  <= 2'b00;
         hmask_q <= 2'b00;
         comp_q  <= 1'b0;
         wo_a_q  <= 1'b0;
         wo_b_q  <= 1'b0;
         cyc_q   <= 1'b0;
      end else begin
         flt_q   <= flt;
         st_q    <= st_d;
         res_q   <= res_d;
         cnt_q   <= cnt_d;
         blk_q   <= blk_d;
         pend_q  <= pend_d;
         hmask_q <= hmask_d;
         comp_q  <= comp_d;
         wo_a_q  <= wo_a_d;
         wo_b_q  <= wo_b_d;
         cyc_q   <= cyc_d;
      end
   end

   assign waveform_out_a_o = wo_a_q;
   assign waveform_out_b_o = wo_b_q;
   assign state_o          = st_q;
   assign cycle_end_o      = cyc_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   chk_wait_hold:
   assert property (enable_i && mode == `PFD_MODE_WAIT && st_q == ST_HOLD
      && (flt & hmask_q) != 2'b00 |=> st_q == ST_HOLD
      && cnt_q == $past(cnt_q)) else $error("hold did not freeze");
   chk_input_own:
   assert property (enable_i && mode == `PFD_MODE_WAIT && flt == 2'b01
      && st_q inside {ST_DTB, ST_OTB} |=> st_q != ST_HOLD)
      else $error("input A acted on channel B");
   chk_alloff_outs:
   assert property (enable_i && mode == `PFD_MODE_ALLOFF && any
      |=> !waveform_out_a_o && !waveform_out_b_o)
      else $error("outputs active during fault");
   chk_dtonly_outs:
   assert property (enable_i && mode == `PFD_MODE_DTONLY && any
      && st_q inside {ST_OTA, ST_OTB} |=> st_q inside {ST_DTA, ST_DTB}
      && !waveform_out_a_o && !waveform_out_b_o)
      else $error("on-time ran during fault");
   chk_swstop_enter:
   assert property (enable_i && mode == `PFD_MODE_SWSTOP && any
      && !(st_q == ST_STOP && restart_i) |=> st_q == ST_STOP)
      else $error("counter not stopped");
   chk_restart_dta:
   assert property (enable_i && st_q == ST_STOP && restart_i
      |=> st_q == ST_DTA && cnt_q == '0) else $error("restart failed");
   chk_edge_jump:
   assert property (enable_i && mode == `PFD_MODE_EDGEJMP && rise[0]
      && st_q == ST_OTA |=> st_q == ST_DTB && cnt_q == '0)
      else $error("edge did not jump");
   chk_edge_blank:
   assert property (enable_i && mode == `PFD_MODE_EDGEBLK && rise[0]
      && st_q == ST_OTA && !done |=> st_q == ST_OTA && !waveform_out_a_o)
      else $error("on-time not blanked");
   chk_dual_nodither:
   assert property (enable_i && mode == `PFD_MODE_NONE && st_q == ST_DTB
      && waveform_generation_mode_i == WGM_DUAL && cnt_q == times_i.dtb
      |=> st_q == ST_OTB) else $error("dither in dual slope");
   chk_idle_mode:
   assert property (enable_i && mode == `PFD_MODE_NONE && st_q == ST_OTA
      && !done |=> st_q == ST_OTA) else $error("idle mode disturbed");
endmodule // pfd_fault_dither

// ---- pfd_fault_src.sv ----
// Model of the two fault sources that feed the block's event inputs.
`timescale 1ns/100ps
module pfd_fault_src (
   input  wire logic slow_i,
   input  wire logic want_a_i,
   input  wire logic want_b_i,
   output logic      fault_a_o,
   output logic      fault_b_o
);
   // The sources are not tied to the timer clock. Each level change lands
   // at an offset inside the period, early or late, so the synchroniser
   // sees both phases.
   initial begin
      fault_a_o = 1'b0;
      forever begin
         @(want_a_i);
         fault_a_o <= #(slow_i ? 6.3 : 2.7) want_a_i;
      end
   end
   initial begin
      fault_b_o = 1'b0;
      forever begin
         @(want_b_i);
         fault_b_o <= #(slow_i ? 6.3 : 2.7) want_b_i;
      end
   end
endmodule // pfd_fault_src

// ---- pfd_fault_dither_tb_top.sv ----
// Self-checking testbench for the fault input and dither block.
`timescale 1ns/100ps
`include "pfd_defs.svh"
module pfd_fault_dither_tb_top;
   import pfd_pkg::*;
   localparam logic [7:0] M_DTA  = 8'h01;
   localparam logic [7:0] M_OTA  = 8'h02;
   localparam logic [7:0] M_OTB  = 8'h08;
   localparam logic [7:0] M_HOLD = 8'h10;
   localparam logic [7:0] M_FREE = 8'h2f;
   logic                   ref_clk_i;
   logic                   rst_i;
   logic                   enable_i;
   logic                   restart_i;
   logic                   slow;
   logic                   want_a;
   logic                   want_b;
   logic                   fault_a;
   logic                   fault_b;
   logic [`PFD_MODE_W-1:0] mode;
   pfd_wgm_t               wgm;
   pfd_dsel_t              dsel;
   logic [`PFD_DIT_W-1:0]  frac;
   pfd_times_t             times;
   logic                   out_a;
   logic                   out_b;
   pfd_state_t             state;
   logic                   cyc_end;
   logic [15:0]            rnd_q;
   logic [7:0]             seen;
   int                     failures;
   int                     num_checks;
   int                     len;
   int                     total;
   int                     base;
   int                     c;
   int                     ends;
   int                     run_len;
   int                     dtb_max;

   pfd_fault_src pfd_fault_src_inst (
      .slow_i    (slow),
      .want_a_i  (want_a),
      .want_b_i  (want_b),
      .fault_a_o (fault_a),
      .fault_b_o (fault_b)
   );
   pfd_fault_dither #(.DIT_W(`PFD_DIT_W)) pfd_fault_dither_inst (
      .ref_clk_i                  (ref_clk_i),
      .rst_i                      (rst_i),
      .enable_i                   (enable_i),
      .fault_a_i                  (fault_a),
      .fault_b_i                  (fault_b),
      .restart_i                  (restart_i),
      .fault_input_mode_i         (mode),
      .waveform_generation_mode_i (wgm),
      .dither_place_select_i      (dsel),
      .dither_frac_i              (frac),
      .times_i                    (times),
      .waveform_out_a_o           (out_a),
      .waveform_out_b_o           (out_b),
      .state_o                    (state),
      .cycle_end_o                (cyc_end)
   );

   initial ref_clk_i = 1'b0;
   always #5 ref_clk_i = ~ref_clk_i;

   // Longest dead-time B run since reset, to see the stretch that the
   // cycle length hides.
   always @(posedge ref_clk_i) begin
      run_len <= (rst_i || state !== ST_DTB) ? 0 : run_len + 1;
      if (rst_i) begin
         dtb_max <= 0;
      end else if (state === ST_DTB && run_len + 1 > dtb_max) begin
         dtb_max <= run_len + 1;
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic int dith_add(input pfd_wgm_t w, input pfd_dsel_t d);
      case (w)
         WGM_ONE:  return (d == DSEL_OTB || d == DSEL_OTAB) ? 1 : 0;
         WGM_TWO:  return (d == DSEL_OTB) ? 1 : ((d == DSEL_OTAB) ? 2 : 0);
         WGM_FOUR: return (d == DSEL_OTB || d == DSEL_DTB) ? 1 : 2;
         default:  return 0;
      endcase
   endfunction

   task automatic complete_run();
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask

   task automatic clk_n(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wait_in(input logic [7:0] mask);
      int n;
      n = 0;
      while (mask[state] !== 1'b1) begin
         clk_n(1);
         n++;
         if (n > 300) begin
            chk(1'b0, "state wait timed out");
            complete_run();
         end
      end
   endtask

   task automatic wait_end(output int n);
      n = 0;
      do begin
         clk_n(1);
         n++;
      end while (cyc_end !== 1'b1 && n < 300);
      chk(n < 300, "cycle end missing");
   endtask

   task automatic set_fault(input logic b, input logic v);
      rnd_q = lfsr(rnd_q);
      slow = rnd_q[0];
      if (b) begin
         want_b = v;
      end else begin
         want_a = v;
      end
   endtask

   task automatic run_mode(input logic [3:0] m);
      want_a = 1'b0;
      want_b = 1'b0;
      rst_i = 1'b1;
      clk_n(3);
      chk(state === ST_DTA && out_a === 1'b0 && out_b === 1'b0, "reset");
      rst_i = 1'b0;
      mode = m;
      enable_i = 1'b1;
   endtask

   initial begin
      rst_i = 1'b1;
      enable_i = 1'b0;
      restart_i = 1'b0;
      want_a = 1'b0;
      want_b = 1'b0;
      slow = 1'b0;
      mode = 4'h0;
      wgm = WGM_TWO;
      dsel = DSEL_OTB;
      frac = 4'h0;
      rnd_q = 16'h0015;
      failures = 0;
      num_checks = 0;
      times = '{dta: 12'h003, ota: 12'h009, dtb: 12'h003, otb: 12'h009};
      clk_n(6);
      for (int k = 0; k < 6; k++) begin
         run_mode((k == 0) ? 4'h0 : 4'(4'ha + k));
         set_fault(1'b0, 1'b1);
         set_fault(1'b1, 1'b1);
         wait_end(len);
         wait_end(len);
         chk(len == 28, "ignored fault changed cycle");
         wait_in(M_OTA);
         chk(out_a === 1'b1, "ignored fault stopped A");
         wait_in(M_OTB);
         chk(out_b === 1'b1, "ignored fault stopped B");
      end
      for (int ch = 0; ch < 2; ch++) begin
         run_mode(`PFD_MODE_WAIT);
         wait_in(ch[0] ? M_OTB : M_OTA);
         set_fault(ch[0], 1'b1);
         clk_n(4);
         chk(state === ST_HOLD, "no hold");
         chk((ch[0] ? out_b : out_a) === 1'b0, "on-time not ended");
         clk_n(10);
         chk(state === ST_HOLD, "hold not kept");
         set_fault(ch[0], 1'b0);
         wait_in(M_FREE);
         chk(state === (ch[0] ? ST_DTA : ST_DTB), "resume wrong");
         run_mode(`PFD_MODE_EDGEJMP);
         wait_in(ch[0] ? M_OTB : M_OTA);
         clk_n(2);
         set_fault(ch[0], 1'b1);
         clk_n(4);
         chk(state === (ch[0] ? ST_DTA : ST_DTB), "edge did not jump");
      end
      run_mode(`PFD_MODE_ALLWAIT);
      wait_in(M_OTA);
      set_fault(1'b1, 1'b1);
      clk_n(4);
      chk(state === ST_HOLD && out_a === 1'b0, "B did not hold A");
      set_fault(1'b1, 1'b0);
      wait_in(M_FREE);
      chk(state === ST_DTB, "resume not other dead-time");
      run_mode(`PFD_MODE_RUN_WT);
      wait_in(M_OTA);
      set_fault(1'b0, 1'b1);
      clk_n(4);
      chk(state === ST_DTB && out_a === 1'b0, "other cycle not run");
      wait_in(M_HOLD);
      set_fault(1'b0, 1'b0);
      wait_in(M_FREE);
      chk(state === ST_DTA, "resume not own dead-time");
      for (int k = 0; k < 3; k++) begin
         run_mode(4'(`PFD_MODE_RUN + k));
         wait_in(M_OTA);
         set_fault(k[0], 1'b1);
         clk_n(4);
         seen = 8'h00;
         ends = 0;
         repeat (60) begin
            seen[state] = 1'b1;
            ends += (cyc_end === 1'b1) ? 1 : 0;
            chk(out_a === 1'b0 && (k == 0 || out_b === 1'b0), "not off");
            clk_n(1);
         end
         chk(seen === ((k == 0) ? 8'h0c : ((k == 1) ? 8'h0f : 8'h05))
             && (k != 1 || ends >= 2), "sequence under fault");
         set_fault(k[0], 1'b0);
         wait_in(M_DTA);
         wait_in(M_OTA);
         chk(out_a === 1'b1, "no on-time after release");
      end
      run_mode(`PFD_MODE_SWSTOP);
      wait_in(M_OTB);
      set_fault(1'b0, 1'b1);
      clk_n(4);
      chk(state === ST_STOP && out_b === 1'b0, "no stop");
      restart_i = 1'b1;
      clk_n(1);
      restart_i = 1'b0;
      clk_n(2);
      chk(state === ST_STOP, "no stop again with fault high");
      set_fault(1'b0, 1'b0);
      clk_n(6);
      chk(state === ST_STOP, "left stop without restart");
      restart_i = 1'b1;
      clk_n(1);
      restart_i = 1'b0;
      chk(state === ST_DTA, "restart not at dead-time A");
      for (int k = 0; k < 2; k++) begin
         run_mode((k == 1) ? `PFD_MODE_LEVBLK : `PFD_MODE_EDGEBLK);
         set_fault(1'b0, k[0]);
         wait_in(M_OTA);
         c = 0;
         while (state === ST_OTA && c < 40) begin
            if (c == 0 && k == 0) chk(out_a === 1'b1, "no on-time A");
            if (c == 1) set_fault(1'b0, 1'b1);
            if (c == 6) set_fault(1'b0, 1'b0);
            if (c >= 5 || k == 1) chk(out_a === 1'b0, "not blanked");
            clk_n(1);
            c++;
         end
         chk(c == 10 && state === ST_DTB, "counter disturbed");
         set_fault(1'b0, 1'b1);
         wait_in(M_OTB);
         chk(out_b === 1'b1, "fault A reached B");
      end
      for (int w = 0; w < 4; w++) begin
         for (int d = 0; d < 4; d++) begin
            rnd_q = lfsr(rnd_q);
            wgm = pfd_wgm_t'(w[1:0]);
            dsel = pfd_dsel_t'(d[1:0]);
            frac = (w == 0 && d == 0) ? 4'hf : rnd_q[15:12];
            times = '{dta: 12'(rnd_q[5:4]) + 12'h001,
                      ota: 12'(rnd_q[7:6]) + 12'h001,
                      dtb: 12'(rnd_q[9:8]) + 12'h001,
                      otb: 12'(rnd_q[11:10]) + 12'h001};
            base = int'(times.dta) + int'(times.ota) + int'(times.dtb)
                   + int'(times.otb) + 4;
            run_mode(4'h0);
            wait_end(len);
            wait_end(len);
            total = 0;
            repeat (16) begin
               wait_end(len);
               total += len;
            end
            chk(total == 16 * base + int'(frac) * dith_add(wgm, dsel),
                "dithered length");
            if (dsel == DSEL_DTB) chk(dtb_max == int'(times.dtb) + 1
                + ((wgm != WGM_DUAL && frac != 0) ? 1 : 0), "stretch");
         end
      end
      complete_run();
   end
endmodule // pfd_fault_dither_tb_top
